//--- rtl/vlu_pkg.sv
// package for the vector load unit: operations, field layouts and interface structs
package vlu_pkg;

    localparam int GPR_W     = 64;
    localparam int ADDR_W    = 64;
    localparam int OFFS_W    = 5;
    localparam int REG_IDX_W = 5;
    localparam logic [REG_IDX_W-1:0] ZERO_GPR_IDX = 5'h00;

    // immediate scale shifts
    localparam int DW_SCALE_SH = 3;
    localparam int HW_SCALE_SH = 1;

    // alignment masks on the low address bits
    localparam logic [2:0] DW_ALIGN_MASK = 3'h7;
    localparam logic [2:0] HW_ALIGN_MASK = 3'h1;

    localparam logic [15:0] HALF_ZERO = 16'h0000;

    // memory access size in bytes
    localparam logic [3:0] SIZE_DW = 4'h8;
    localparam logic [3:0] SIZE_HW = 4'h2;

    typedef enum logic [2:0] {
        VLU_OP_DW,
        VLU_OP_FOUR_HALF,
        VLU_OP_TWO_WORD,
        VLU_OP_HALF_EVEN_SPLAT,
        VLU_OP_HALF_ODD_SIGNED_SPLAT
    } vlu_op_t;

    typedef struct packed {
        vlu_op_t                op;
        logic                   indexed;
        logic [REG_IDX_W-1:0]   base_gpr_idx;
        logic [GPR_W-1:0]       base_gpr;
        logic [GPR_W-1:0]       index_gpr;
        logic [OFFS_W-1:0]      unsigned_offset_field;
        logic [REG_IDX_W-1:0]   dest_idx;
        logic                   little_endian;
    } vlu_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0]      effective_addr;
        logic [3:0]             size;
    } vlu_mem_req_t;

    typedef struct packed {
        logic [REG_IDX_W-1:0]   dest_idx;
        logic [GPR_W-1:0]       data;
    } vlu_wb_t;

endpackage : vlu_pkg

//--- rtl/vlu_lane_format.sv
// byte placement of raw memory data into the destination register
`timescale 1ns/1ps
module vlu_lane_format (
    // operation
    input  wire vlu_pkg::vlu_op_t op_in,
    input  wire logic             little_endian_in,
    // memory bytes, byte at lowest address in bits 63:56
    input  wire logic [63:0]      mem_data_in,
    // formatted destination value
    output logic [63:0]           gpr_value_out
);

    // bytes in address order: byte k is at effective_addr+k
    wire [7:0] mem_byte [0:7];
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bytes
            assign mem_byte[g] = mem_data_in[63-8*g -: 8];
        end
    endgenerate

    wire le = little_endian_in;
    // little endian reverses bytes inside each element
    wire [63:0] dw_val = le ?
        {mem_byte[7], mem_byte[6], mem_byte[5], mem_byte[4],
         mem_byte[3], mem_byte[2], mem_byte[1], mem_byte[0]} : mem_data_in;

    wire [63:0] word_val = le ?
        {mem_byte[3], mem_byte[2], mem_byte[1], mem_byte[0],
         mem_byte[7], mem_byte[6], mem_byte[5], mem_byte[4]} : mem_data_in;

    wire [63:0] half_val = le ?
        {mem_byte[1], mem_byte[0], mem_byte[3], mem_byte[2],
         mem_byte[5], mem_byte[4], mem_byte[7], mem_byte[6]} : mem_data_in;

    // single halfword at effective_addr, endian ordered
    wire [15:0] one_half = le ? {mem_byte[1], mem_byte[0]}
                              : {mem_byte[0], mem_byte[1]};
    // sign comes from the lower byte in big endian, higher byte in little
    wire        half_sign = le ? mem_byte[1][7] : mem_byte[0][7];
    wire [31:0] half_sext = {{16{half_sign}}, one_half};

    wire [63:0] even_splat = {one_half, vlu_pkg::HALF_ZERO,
                              one_half, vlu_pkg::HALF_ZERO};
    wire [63:0] odd_splat  = {half_sext, half_sext};

    always_comb begin
        unique case (op_in)
            vlu_pkg::VLU_OP_DW:                    gpr_value_out = dw_val;
            vlu_pkg::VLU_OP_FOUR_HALF:             gpr_value_out = half_val;
            vlu_pkg::VLU_OP_TWO_WORD:              gpr_value_out = word_val;
            vlu_pkg::VLU_OP_HALF_EVEN_SPLAT:       gpr_value_out = even_splat;
            vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT: gpr_value_out = odd_splat;
            default:                               gpr_value_out = 64'h0;
        endcase
    end

endmodule : vlu_lane_format

//--- rtl/vlu_vector_load_unit.sv
// vector load unit: address generation, memory request, formatting, alignment check
`timescale 1ns/1ps
// What this block does
// - base register zero means base value zero
// - doubleword displacement: base plus offset times eight
// - indexed forms: base plus full index register
// - doubleword load writes eight bytes to destination
// - four halfwords from address plus 0,2,4,6
// - two words from address and address plus 4
// - doubleword forms fault unless address eight-aligned
// - halfword splat displacement: offset times two
// - even splat fills even halves, clears odd
// - odd signed splat sign-extends into both words
// - sign byte lower in big, higher little
// - halfword splat forms fault unless two-aligned
// - byte placement follows current endian mode
module vlu_vector_load_unit #(
    // data path width; the byte lanes are laid out for 64 bits only
    parameter int DATA_W = vlu_pkg::GPR_W
) (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    // request from the issue stage
    input  wire logic                  req_valid_in,
    input  wire vlu_pkg::vlu_req_t     req_in,
    output logic                       req_ready_out,
    // data memory path
    output logic                       mem_req_valid_out,
    output vlu_pkg::vlu_mem_req_t      mem_req_out,
    input  wire logic                  mem_req_ready_in,
    input  wire logic                  mem_rsp_valid_in,
    input  wire logic [DATA_W-1:0]     mem_rsp_data_in,
    // register write back
    output logic                       wb_valid_out,
    output vlu_pkg::vlu_wb_t           wb_out,
    // exception report
    output logic                       align_exc_out,
    output logic [63:0]                align_exc_addr_out
);

    // lane formatting and the write back struct assume a 64-bit register file
    if (DATA_W != 64) begin : g_width_check
        $error("vector load unit serves a 64-bit data path only");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // effective address

    typedef enum logic [1:0] {VLU_IDLE, VLU_ISSUE, VLU_WAIT} vlu_state_t;

    vlu_state_t state_q;
    vlu_state_t state_d;

    wire vlu_pkg::vlu_req_t r = req_in;

    wire base_is_zero = (r.base_gpr_idx == vlu_pkg::ZERO_GPR_IDX);
    wire [63:0] base_val = base_is_zero ? 64'h0 : r.base_gpr;

    wire is_half_op = (r.op == vlu_pkg::VLU_OP_HALF_EVEN_SPLAT) ||
                      (r.op == vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT);

    wire [63:0] offs_ext = {59'h0, r.unsigned_offset_field};
    wire [63:0] disp_dw  = offs_ext << vlu_pkg::DW_SCALE_SH;
    wire [63:0] disp_hw  = offs_ext << vlu_pkg::HW_SCALE_SH;
    wire [63:0] disp     = r.indexed ? r.index_gpr
                                     : (is_half_op ? disp_hw : disp_dw);
    wire [63:0] ea       = base_val + disp;

    wire [2:0] align_mask = is_half_op ? vlu_pkg::HW_ALIGN_MASK : vlu_pkg::DW_ALIGN_MASK;
    wire misaligned = (ea[2:0] & align_mask) != 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // request and response handling

    vlu_pkg::vlu_op_t              op_q;
    logic                          le_q;
    logic [vlu_pkg::REG_IDX_W-1:0] dest_q;
    vlu_pkg::vlu_mem_req_t         mreq_q;
    logic                          wb_valid_q;
    vlu_pkg::vlu_wb_t              wb_q;
    logic                          exc_q;
    logic [63:0]                   exc_addr_q;

    wire accept    = req_valid_in && (state_q == VLU_IDLE);
    wire take_exc  = accept && misaligned;
    wire take_load = accept && !misaligned;
    wire issued    = (state_q == VLU_ISSUE) && mem_req_ready_in;
    wire got_rsp   = (state_q == VLU_WAIT) && mem_rsp_valid_in;

    logic [63:0] fmt_data;

    vlu_lane_format u_format (
        .op_in            (op_q),
        .little_endian_in (le_q),
        .mem_data_in      (mem_rsp_data_in),
        .gpr_value_out    (fmt_data)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            VLU_IDLE:  if (take_load) state_d = VLU_ISSUE;
            VLU_ISSUE: if (issued) state_d = VLU_WAIT;
            VLU_WAIT:  if (got_rsp) state_d = VLU_IDLE;
            default:   state_d = VLU_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= VLU_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            op_q   <= vlu_pkg::VLU_OP_DW;
            le_q   <= 1'b0;
            dest_q <= '0;
            mreq_q <= '0;
        end else if (take_load) begin
            op_q   <= r.op;
            le_q   <= r.little_endian;
            dest_q <= r.dest_idx;
            mreq_q <= '{effective_addr: ea,
                        size: (is_half_op ? vlu_pkg::SIZE_HW : vlu_pkg::SIZE_DW)};
        end
    end

    // write back only on a clean response; a faulting request never writes
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wb_valid_q <= 1'b0;
            wb_q       <= '0;
        end else begin
            wb_valid_q <= got_rsp;
            if (got_rsp) begin
                wb_q <= '{dest_idx: dest_q, data: fmt_data};
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            exc_q      <= 1'b0;
            exc_addr_q <= 64'h0;
        end else begin
            exc_q <= take_exc;
            if (take_exc) begin
                exc_addr_q <= ea;
            end
        end
    end

    assign req_ready_out      = (state_q == VLU_IDLE);
    assign mem_req_valid_out  = (state_q == VLU_ISSUE);
    assign mem_req_out        = mreq_q;
    assign wb_valid_out       = wb_valid_q;
    assign wb_out             = wb_q;
    assign align_exc_out      = exc_q;
    assign align_exc_addr_out = exc_addr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_zero_base;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_load && base_is_zero && r.indexed |=>
            mem_req_out.effective_addr == $past(r.index_gpr);
    endproperty
    a_zero_base: assert property (p_zero_base) else $error("zero base not used");

    property p_dw_disp;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_load && !r.indexed && !is_half_op |=>
            mem_req_out.effective_addr ==
            $past(base_val) + {56'h0, $past(r.unsigned_offset_field), 3'h0};
    endproperty
    a_dw_disp: assert property (p_dw_disp) else $error("dw displacement wrong");

    property p_indexed;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_load && r.indexed |=>
            mem_req_out.effective_addr == $past(base_val) + $past(r.index_gpr);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_hw_disp;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_load && !r.indexed && is_half_op |=>
            mem_req_out.effective_addr ==
            $past(base_val) + {58'h0, $past(r.unsigned_offset_field), 1'b0};
    endproperty
    a_hw_disp: assert property (p_hw_disp) else $error("hw displacement wrong");

    property p_dw_align;
        @(posedge clock_in) disable iff (!rst_b_in)
        accept && !is_half_op && (ea[2:0] != 3'h0) |=> align_exc_out && !mem_req_valid_out;
    endproperty
    a_dw_align: assert property (p_dw_align) else $error("dw misalign not caught");

    property p_hw_align;
        @(posedge clock_in) disable iff (!rst_b_in)
        accept && is_half_op |=> (align_exc_out == $past(ea[0]));
    endproperty
    a_hw_align: assert property (p_hw_align) else $error("hw alignment wrong");

    property p_no_wb_on_exc;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_exc |=> !wb_valid_out ##1 !wb_valid_out;
    endproperty
    a_no_wb_on_exc: assert property (p_no_wb_on_exc) else $error("write after fault");

    property p_even_zero;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_HALF_EVEN_SPLAT |=>
            wb_out.data[47:32] == 16'h0000 && wb_out.data[15:0] == 16'h0000 &&
            wb_out.data[63:48] == wb_out.data[31:16];
    endproperty
    a_even_zero: assert property (p_even_zero) else $error("even splat wrong");

    property p_odd_sext;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT |=>
            wb_out.data[63:32] == wb_out.data[31:0] &&
            wb_out.data[31:16] == {16{wb_out.data[15]}};
    endproperty
    a_odd_sext: assert property (p_odd_sext) else $error("odd splat wrong");

    property p_dw_be;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_DW && !le_q |=>
            wb_out.data == $past(mem_rsp_data_in);
    endproperty
    a_dw_be: assert property (p_dw_be) else $error("dw big endian wrong");

    property p_word_le;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_TWO_WORD && le_q |=>
            wb_out.data[63:56] == $past(mem_rsp_data_in[39:32]);
    endproperty
    a_word_le: assert property (p_word_le) else $error("word le wrong");

    property p_load_done;
        @(posedge clock_in) disable iff (!rst_b_in)
        mem_rsp_valid_in && state_q == VLU_WAIT |=> wb_valid_out && req_ready_out;
    endproperty
    a_load_done: assert property (p_load_done) else $error("load not completed");

    // the two bytes of every halfword trade places in little endian mode
    property p_half_le;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_FOUR_HALF && le_q |=>
            wb_out.data[63:48] == {$past(mem_rsp_data_in[55:48]), $past(mem_rsp_data_in[63:56])};
    endproperty
    a_half_le: assert property (p_half_le) else $error("four half le wrong");

    // a little endian doubleword is fully byte reversed
    property p_dw_le;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_DW && le_q |=>
            wb_out.data[7:0] == $past(mem_rsp_data_in[63:56]) &&
            wb_out.data[63:56] == $past(mem_rsp_data_in[7:0]);
    endproperty
    a_dw_le: assert property (p_dw_le) else $error("dw little endian wrong");

    property p_word_be;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_TWO_WORD && !le_q |=>
            wb_out.data == $past(mem_rsp_data_in);
    endproperty
    a_word_be: assert property (p_word_be) else $error("two word big endian wrong");

    // sign source byte flips with the endian mode
    property p_sign_src;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT |=>
            wb_out.data[31] == (le_q ? $past(mem_rsp_data_in[55]) : $past(mem_rsp_data_in[63]));
    endproperty
    a_sign_src: assert property (p_sign_src) else $error("splat sign byte wrong");

    // a fault reports its address and frees the unit at once
    property p_exc_addr;
        @(posedge clock_in) disable iff (!rst_b_in)
        take_exc |=> align_exc_addr_out == $past(ea) && req_ready_out;
    endproperty
    a_exc_addr: assert property (p_exc_addr) else $error("fault address wrong");

    property p_even_value;
        @(posedge clock_in) disable iff (!rst_b_in)
        got_rsp && op_q == vlu_pkg::VLU_OP_HALF_EVEN_SPLAT && !le_q |=>
            wb_out.data[63:48] == $past(mem_rsp_data_in[63:48]);
    endproperty
    a_even_value: assert property (p_even_value) else $error("even splat value wrong");

    c_dw_load:  cover property (@(posedge clock_in) take_load && r.op == vlu_pkg::VLU_OP_DW);
    c_splat_le: cover property (@(posedge clock_in)
                                got_rsp && le_q && op_q == vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT);
    c_exc:      cover property (@(posedge clock_in) take_exc);
    c_stall:    cover property (@(posedge clock_in) mem_req_valid_out && !mem_req_ready_in);

endmodule : vlu_vector_load_unit

//--- verification/vlu_mem_model.sv
// data memory partner model for the vector load unit bench
`timescale 1ns/1ps
module vlu_mem_model (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    // request from the unit
    input  wire logic                  mem_req_valid_in,
    input  wire vlu_pkg::vlu_mem_req_t mem_req_in,
    output logic                       mem_req_ready_out,
    // response to the unit
    output logic                       mem_rsp_valid_out,
    output logic [63:0]                mem_rsp_data_out,
    // wait cycles before accept and before answer
    input  wire logic [1:0]            delay_in
);
    logic [1:0]  cnt_q;
    logic        pend_q;
    logic [63:0] addr_q;

    ////////////////////////////////////////
    function automatic logic [7:0] mem_byte(input logic [63:0] a);
        return a[7:0] * 8'h25 + a[15:8] + 8'h0b;
    endfunction : mem_byte

    function automatic logic [63:0] dword(input logic [63:0] a);
        logic [63:0] r;
        for (int k = 0; k < 8; k++) r[63-8*k -: 8] = mem_byte(a + k);
        return r;
    endfunction : dword

    ////////////////////////////////////////
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mem_req_ready_out <= 1'b0;
            mem_rsp_valid_out <= 1'b0;
            mem_rsp_data_out  <= 64'h0;
            cnt_q             <= 2'h0;
            pend_q            <= 1'b0;
            addr_q            <= 64'h0;
        end else begin
            mem_req_ready_out <= 1'b0;
            mem_rsp_valid_out <= 1'b0;
            // idle bus toggles so a stale word can never pass for an answer
            mem_rsp_data_out  <= ~mem_rsp_data_out;
            if (mem_req_ready_out) begin
                pend_q <= 1'b1;
            end
            if (mem_req_valid_in && !mem_req_ready_out && !pend_q) begin
                if (cnt_q == delay_in) begin
                    mem_req_ready_out <= 1'b1;
                    addr_q            <= mem_req_in.effective_addr;
                    cnt_q             <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
            if (pend_q) begin
                if (cnt_q == delay_in) begin
                    mem_rsp_valid_out <= 1'b1;
                    mem_rsp_data_out  <= dword(addr_q);
                    pend_q            <= 1'b0;
                    cnt_q             <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule : vlu_mem_model

//--- verification/test_vector_load_unit.sv
// self-checking bench for the vector load unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module test_vector_load_unit;
    logic                  clock_in;
    logic                  rst_b_in;
    logic                  req_valid_in;
    vlu_pkg::vlu_req_t     req_in;
    logic                  req_ready_out;
    logic                  mem_req_valid_out;
    vlu_pkg::vlu_mem_req_t mem_req_out;
    logic                  mem_req_ready_in;
    logic                  mem_rsp_valid_in;
    logic [63:0]           mem_rsp_data_in;
    logic                  wb_valid_out;
    vlu_pkg::vlu_wb_t      wb_out;
    logic                  align_exc_out;
    logic [63:0]           align_exc_addr_out;
    logic [1:0]            mem_delay;
    int                    fail_count;
    int                    n_checks;
    int                    cycles;

    vlu_vector_load_unit i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .mem_req_valid_out(mem_req_valid_out), .mem_req_out(mem_req_out),
        .mem_req_ready_in(mem_req_ready_in), .mem_rsp_valid_in(mem_rsp_valid_in),
        .mem_rsp_data_in(mem_rsp_data_in), .wb_valid_out(wb_valid_out), .wb_out(wb_out),
        .align_exc_out(align_exc_out), .align_exc_addr_out(align_exc_addr_out));

    vlu_mem_model i_mem (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .mem_req_valid_in(mem_req_valid_out), .mem_req_in(mem_req_out),
        .mem_req_ready_out(mem_req_ready_in), .mem_rsp_valid_out(mem_rsp_valid_in),
        .mem_rsp_data_out(mem_rsp_data_in), .delay_in(mem_delay));

    ////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    // 48 loads of at most 20 cycles each
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            summarize();
        end
    end

    ////////////////////////////////////////
    function automatic logic [63:0] expect_val(input vlu_pkg::vlu_op_t op, input logic le,
                                               input logic [63:0] ea);
        logic [63:0] r;
        logic [15:0] h;
        int          sw;
        sw = (op == vlu_pkg::VLU_OP_DW) ? 7 : (op == vlu_pkg::VLU_OP_TWO_WORD) ? 3 : 1;
        for (int k = 0; k < 8; k++) r[63-8*k -: 8] = i_mem.mem_byte(ea + (le ? (k ^ sw) : k));
        h = r[63:48];
        if (op == vlu_pkg::VLU_OP_HALF_EVEN_SPLAT) r = {h, 16'h0000, h, 16'h0000};
        if (op == vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT) r = {2{{16{h[15]}}, h}};
        return r;
    endfunction : expect_val

    task automatic do_load(input vlu_pkg::vlu_op_t op, input logic ix, input logic [4:0] bidx,
                           input logic [63:0] base, input logic [63:0] idx,
                           input logic [4:0] off, input logic le);
        logic [63:0] ea;
        logic        hw;
        logic        bad;
        logic        got_wb;
        logic        got_exc;
        logic        got_mem;
        int          n;
        hw = (op > vlu_pkg::VLU_OP_TWO_WORD);
        ea = (bidx == 5'h00 ? 64'h0 : base) + (ix ? idx : ({59'h0, off} << (hw ? 1 : 3)));
        bad = hw ? ea[0] : (ea[2:0] != 3'h0);
        got_wb = 1'b0;
        got_exc = 1'b0;
        got_mem = 1'b0;
        req_in = '{op: op, indexed: ix, base_gpr_idx: bidx, base_gpr: base, index_gpr: idx,
                   unsigned_offset_field: off, dest_idx: ~bidx, little_endian: le};
        req_valid_in = 1'b1;
        for (n = 0; n < 50 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
        @(negedge clock_in);
        req_valid_in = 1'b0;
        `CHK("ready", bad, req_ready_out)
        for (n = 0; n < 16; n++) begin
            if (mem_req_valid_out === 1'b1 && !got_mem) begin
                got_mem = 1'b1;
                `CHK("address", ea, mem_req_out.effective_addr)
                `CHK("size", hw ? vlu_pkg::SIZE_HW : vlu_pkg::SIZE_DW, mem_req_out.size)
            end
            if (wb_valid_out === 1'b1) begin
                got_wb = 1'b1;
                `CHK("dest", ~bidx, wb_out.dest_idx)
                `CHK("data", expect_val(op, le, ea), wb_out.data)
            end
            if (align_exc_out === 1'b1) begin
                got_exc = 1'b1;
                `CHK("fault address", ea, align_exc_addr_out)
            end
            @(negedge clock_in);
        end
        `CHK("fault", bad, got_exc)
        `CHK("write back", ~bad, got_wb)
        `CHK("memory access", ~bad, got_mem)
    endtask : do_load

    ////////////////////////////////////////
    task automatic t_disp_forms;
        for (int le = 0; le < 2; le++) begin
            do_load(vlu_pkg::VLU_OP_DW, 1'b0, 5'h03, 64'h1000, 64'h0, 5'h1f, le[0]);
            do_load(vlu_pkg::VLU_OP_TWO_WORD, 1'b0, 5'h04, 64'h2000, 64'h0, 5'h05, le[0]);
            do_load(vlu_pkg::VLU_OP_HALF_EVEN_SPLAT, 1'b0, 5'h05, 64'h3000, 64'h0, 5'h1f, le[0]);
        end
        $display("test disp_forms done");
    endtask : t_disp_forms

    task automatic t_indexed_forms;
        // base field zero must ignore a non-zero base value
        do_load(vlu_pkg::VLU_OP_DW, 1'b1, 5'h00, 64'hffff_0000_0000_0007, 64'h2a48, 5'h1f, 1'b0);
        do_load(vlu_pkg::VLU_OP_TWO_WORD, 1'b0, 5'h00, 64'h0000_0000_0000_0105, 64'h0, 5'h02, 1'b1);
        for (int le = 0; le < 2; le++) begin
            do_load(vlu_pkg::VLU_OP_FOUR_HALF, 1'b1, 5'h06, 64'h8000_0000_0000_0100, 64'h38, 5'h1f,
                    le[0]);
            do_load(vlu_pkg::VLU_OP_HALF_EVEN_SPLAT, 1'b1, 5'h06, 64'h3001, 64'h1, 5'h00, le[0]);
        end
        $display("test indexed_forms done");
    endtask : t_indexed_forms

    task automatic t_signed_splat;
        // addresses 0x4000 to 0x4006; only at 0x4004 do the two bytes carry opposite sign bits
        for (int le = 0; le < 2; le++) begin
            for (int a = 0; a < 8; a += 2) begin
                do_load(vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT, 1'b1, 5'h07, 64'h4000, a, 5'h00,
                        le[0]);
            end
            do_load(vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT, 1'b0, 5'h07, 64'h4000, 64'h0, 5'h02,
                    le[0]);
        end
        $display("test signed_splat done");
    endtask : t_signed_splat

    task automatic t_misaligned;
        vlu_pkg::vlu_op_t ops[3];
        ops = '{vlu_pkg::VLU_OP_DW, vlu_pkg::VLU_OP_FOUR_HALF, vlu_pkg::VLU_OP_TWO_WORD};
        for (int i = 0; i < 3; i++) begin
            for (int k = 1; k < 8; k++) do_load(ops[i], 1'b1, 5'h01, 64'h5000, k, 5'h00, 1'b0);
        end
        do_load(vlu_pkg::VLU_OP_HALF_EVEN_SPLAT, 1'b1, 5'h01, 64'h5000, 64'h3, 5'h00, 1'b0);
        do_load(vlu_pkg::VLU_OP_HALF_ODD_SIGNED_SPLAT, 1'b0, 5'h01, 64'h5001, 64'h0, 5'h04, 1'b1);
        do_load(vlu_pkg::VLU_OP_DW, 1'b1, 5'h01, 64'h5000, 64'h8, 5'h00, 1'b0);
        $display("test misaligned done");
    endtask : t_misaligned

    task automatic t_slow_memory;
        mem_delay = 2'h3;
        do_load(vlu_pkg::VLU_OP_DW, 1'b0, 5'h02, 64'h6000, 64'h0, 5'h01, 1'b1);
        do_load(vlu_pkg::VLU_OP_FOUR_HALF, 1'b1, 5'h02, 64'h6000, 64'h10, 5'h00, 1'b0);
        mem_delay = 2'h0;
        $display("test slow_memory done");
    endtask : t_slow_memory

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    ////////////////////////////////////////
    initial begin
        rst_b_in = 1'b0;
        req_valid_in = 1'b0;
        req_in = '0;
        mem_delay = 2'h0;
        fail_count = 0;
        n_checks = 0;
        cycles = 0;
        repeat (7) @(negedge clock_in);
        rst_b_in = 1'b1;
        @(negedge clock_in);
        t_disp_forms();
        t_indexed_forms();
        t_signed_splat();
        t_misaligned();
        t_slow_memory();
        summarize();
    end
endmodule : test_vector_load_unit
